// file: lpwc_crop.sv
// The APB register port and the register offsets were left to the implementer.
module lpwc_crop
    import lpwc_pkg::*;
#(
    parameter int unsigned LINE_PIX = LPWC_LINE_PIX_DEFAULT
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_line_valid,
    input wire logic in_pix_valid,
    input wire logic in_line_b,
    input wire logic [LPWC_DATA_W-1:0] in_pix,
    output logic out_line_valid,
    output logic out_pix_valid,
    output logic out_line_b,
    output logic [LPWC_DATA_W-1:0] out_pix,
    output logic out_line_end,
    output logic win_range_err
);
    if (LINE_PIX != LPWC_LINE_PIX_DEFAULT && LINE_PIX != LPWC_LINE_PIX_ALT) begin : g_width_chk
        $error("line width must be 2048 or 4096");
    end

    lpwc_win_if win();
    lpwc_state_t state_reg;
    lpwc_state_t state_next;
    logic [LPWC_PIX_W:0] first_act_reg;
    logic [LPWC_PIX_W:0] count_act_reg;
    logic bin_act_reg;
    logic single_act_reg;
    logic pending_reg;
    logic [LPWC_PIX_W:0] pix_idx_reg;
    logic half_reg;
    logic [LPWC_DATA_W:0] sum_reg;
    logic lv_d_reg;
    logic pready_reg;
    logic [31:0] prdata_w;
    logic pslverr_w;

    // mean of a pixel pair, carry kept so no overflow
    function automatic logic [LPWC_DATA_W-1:0] merged_sum(
        input logic [LPWC_DATA_W-1:0] a,
        input logic [LPWC_DATA_W-1:0] b
    );
        logic [LPWC_DATA_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        merged_sum = s[LPWC_DATA_W:1];
    endfunction : merged_sum

    lpwc_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .busy(state_reg == LPWC_RUN),
        .prdata(prdata_w),
        .pslverr(pslverr_w),
        .win(win.regs)
    );

    wire line_start = in_line_valid && !lv_d_reg;
    wire line_stop = !in_line_valid && lv_d_reg;
    // binned width is half the physical one
    wire [LPWC_PIX_W:0] width_eff = bin_act_reg ? (LPWC_PIX_W+1)'(LINE_PIX / 2)
                                                : (LPWC_PIX_W+1)'(LINE_PIX);
    // bound check: first + count <= width + 1
    wire [LPWC_PIX_W+1:0] win_end = {1'b0, first_act_reg} + {1'b0, count_act_reg};
    wire range_bad = win_end > ({1'b0, width_eff} + 14'h0001);
    // single line: crop line A only
    wire crop_this = !(single_act_reg && in_line_b);
    // merged pixel ready every second input pixel
    wire pix_out_stb = in_line_valid && in_pix_valid && (!bin_act_reg || half_reg);
    wire [LPWC_PIX_W:0] idx1 = pix_idx_reg + LPWC_PIX_ONE;
    wire in_win = !crop_this ||
        (idx1 >= first_act_reg && {1'b0, idx1} < win_end);
    wire [LPWC_DATA_W-1:0] pix_val = bin_act_reg ?
        merged_sum(sum_reg[LPWC_DATA_W-1:0], in_pix) : in_pix;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LPWC_IDLE: if (line_start) state_next = LPWC_RUN;
            LPWC_RUN: if (line_stop) state_next = LPWC_DONE;
            LPWC_DONE: state_next = LPWC_IDLE;
            default: state_next = LPWC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state_reg <= LPWC_IDLE;
        else state_reg <= state_next;
    end

    // shadow copies loaded only between lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_act_reg <= LPWC_FIRST_RST;
            count_act_reg <= LPWC_COUNT_RST;
            bin_act_reg <= 1'b0;
            single_act_reg <= 1'b0;
            pending_reg <= 1'b0;
        end else if (state_reg == LPWC_IDLE && !line_start) begin
            first_act_reg <= win.first;
            count_act_reg <= win.count;
            bin_act_reg <= win.bin_en;
            single_act_reg <= win.single_line;
            // a write in the copy cycle lands next cycle, so it stays pending
            pending_reg <= win.wr_stb;
        end else if (win.wr_stb) begin
            pending_reg <= 1'b1;
        end
    end
    assign win.pending = pending_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_d_reg <= 1'b0;
            pix_idx_reg <= '0;
            half_reg <= 1'b0;
            sum_reg <= '0;
        end else begin
            lv_d_reg <= in_line_valid;
            if (!in_line_valid) begin
                pix_idx_reg <= '0;
                half_reg <= 1'b0;
            end else if (in_pix_valid) begin
                half_reg <= bin_act_reg && !half_reg;
                sum_reg <= {1'b0, in_pix};
                if (pix_out_stb) pix_idx_reg <= idx1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_line_valid <= 1'b0;
            out_pix_valid <= 1'b0;
            out_line_b <= 1'b0;
            out_pix <= '0;
            out_line_end <= 1'b0;
            win_range_err <= 1'b0;
            pready_reg <= 1'b0;
        end else begin
            out_line_valid <= in_line_valid;
            out_pix_valid <= pix_out_stb && in_win;
            out_line_b <= in_line_b;
            out_pix <= (pix_out_stb && in_win) ? pix_val : '0;
            out_line_end <= line_stop;
            win_range_err <= range_bad;
            pready_reg <= psel && !penable;
        end
    end

    assign prdata = prdata_w;
    assign pslverr = pslverr_w;
    assign pready = pready_reg;
endmodule : lpwc_crop

// file: lpwc_pkg.sv
package lpwc_pkg;
    localparam int unsigned LPWC_PIX_W = 12;
    localparam int unsigned LPWC_DATA_W = 16;
    localparam int unsigned LPWC_LINE_PIX_DEFAULT = 4096;
    localparam int unsigned LPWC_LINE_PIX_ALT = 2048;
    localparam logic [LPWC_PIX_W:0] LPWC_PIX_ONE = 13'h0001;
    // register byte addresses
    localparam logic [7:0] LPWC_OFS_FIRST = 8'h00;
    localparam logic [7:0] LPWC_OFS_COUNT = 8'h04;
    localparam logic [7:0] LPWC_OFS_CTRL = 8'h08;
    localparam logic [7:0] LPWC_OFS_STATUS = 8'h0C;
    // ctrl fields
    localparam int unsigned LPWC_CTRL_BIN_BIT = 0;
    localparam int unsigned LPWC_CTRL_SINGLE_BIT = 1;
    // status fields
    localparam int unsigned LPWC_STAT_BUSY_BIT = 0;
    localparam int unsigned LPWC_STAT_PEND_BIT = 1;
    localparam int unsigned LPWC_STAT_BIN_BIT = 2;
    // reset values: full line
    localparam logic [LPWC_PIX_W:0] LPWC_FIRST_RST = 13'h0001;
    localparam logic [LPWC_PIX_W:0] LPWC_COUNT_RST = 13'h1000;
    typedef enum logic [1:0] {
        LPWC_IDLE = 2'b00,
        LPWC_RUN = 2'b01,
        LPWC_DONE = 2'b11
    } lpwc_state_t;
endpackage : lpwc_pkg

// file: lpwc_win_if.sv
interface lpwc_win_if
    import lpwc_pkg::*;
;
    logic [LPWC_PIX_W:0] first;
    logic [LPWC_PIX_W:0] count;
    logic bin_en;
    logic single_line;
    logic wr_stb;
    logic pending;
    modport regs (output first, output count, output bin_en, output single_line,
        output wr_stb, input pending);
    modport core (input first, input count, input bin_en, input single_line,
        input wr_stb, output pending);
endinterface : lpwc_win_if

// file: lpwc_regs.sv
module lpwc_regs
    import lpwc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic busy,
    output logic [31:0] prdata,
    output logic pslverr,
    lpwc_win_if.regs win
);
    logic [LPWC_PIX_W:0] first_reg;
    logic [LPWC_PIX_W:0] count_reg;
    logic [1:0] ctrl_reg;
    logic [31:0] rdata_next;
    wire acc = psel && penable;
    // read data and error are launched at the setup edge so they stand with pready
    wire setup = psel && !penable;
    wire wr = acc && pwrite;
    wire hit_first = paddr == LPWC_OFS_FIRST;
    wire hit_count = paddr == LPWC_OFS_COUNT;
    wire hit_ctrl = paddr == LPWC_OFS_CTRL;
    wire hit_stat = paddr == LPWC_OFS_STATUS;
    wire mapped = hit_first || hit_count || hit_ctrl || hit_stat;

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_first) rdata_next[LPWC_PIX_W:0] = first_reg;
        if (hit_count) rdata_next[LPWC_PIX_W:0] = count_reg;
        if (hit_ctrl) rdata_next[1:0] = ctrl_reg;
        if (hit_stat) begin
            rdata_next[LPWC_STAT_BUSY_BIT] = busy;
            rdata_next[LPWC_STAT_PEND_BIT] = win.pending;
            rdata_next[LPWC_STAT_BIN_BIT] = ctrl_reg[LPWC_CTRL_BIN_BIT];
        end
    end

    // separate start and length registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_reg <= LPWC_FIRST_RST;
            count_reg <= LPWC_COUNT_RST;
            ctrl_reg <= 2'h0;
        end else if (wr) begin
            if (hit_first) first_reg <= pwdata[LPWC_PIX_W:0];
            if (hit_count) count_reg <= pwdata[LPWC_PIX_W:0];
            if (hit_ctrl) ctrl_reg <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata <= (setup && !pwrite) ? rdata_next : 32'h0000_0000;
            pslverr <= setup && !mapped;
        end
    end

    assign win.first = first_reg;
    assign win.count = count_reg;
    assign win.bin_en = ctrl_reg[LPWC_CTRL_BIN_BIT];
    assign win.single_line = ctrl_reg[LPWC_CTRL_SINGLE_BIT];
    assign win.wr_stb = wr && (hit_first || hit_count || hit_ctrl);
endmodule : lpwc_regs

// file: lpwc_grabber.sv
module lpwc_grabber
    import lpwc_pkg::*;
(
    input wire logic pclk,
    input wire logic line_valid,
    input wire logic pix_valid,
    input wire logic [LPWC_DATA_W-1:0] pix,
    output int n_pix,
    output logic [LPWC_DATA_W-1:0] first_pix,
    output logic [LPWC_DATA_W-1:0] last_pix
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lv_q = 1'b0;
    initial n_pix = 0;
    // counts each kept pixel of a line, restarts at line start
    always @(posedge pclk) begin
        lv_q <= line_valid;
        if (line_valid && !lv_q) begin
            n_pix <= 0;
        end else if (pix_valid) begin
            if (n_pix == 0) first_pix <= pix;
            last_pix <= pix;
            n_pix <= n_pix + 1;
        end
    end
endmodule : lpwc_grabber

// file: lpwc_crop_props.sv
module lpwc_crop_chk
    import lpwc_pkg::*;
#(
    parameter int unsigned LINE_PIX = LPWC_LINE_PIX_DEFAULT
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic in_line_valid,
    input wire logic in_pix_valid,
    input wire logic in_line_b,
    input wire logic out_line_valid,
    input wire logic out_pix_valid,
    input wire logic out_line_b,
    input wire logic [LPWC_DATA_W-1:0] out_pix,
    input wire logic out_line_end
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_rdy1; pready |=> !pready; endproperty
    a_rdy1: assert property (p_rdy1) else $error("ready held");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_lat; out_pix_valid |-> $past(in_pix_valid) && $past(in_line_valid); endproperty
    a_lat: assert property (p_lat) else $error("pixel without input");
    property p_zero; !out_pix_valid |-> out_pix == 16'h0000; endproperty
    a_zero: assert property (p_zero) else $error("pixel data idle");
    property p_line; in_line_valid |=> out_line_valid; endproperty
    a_line: assert property (p_line) else $error("line valid lost");
    property p_end; $fell(in_line_valid) |=> out_line_end; endproperty
    a_end: assert property (p_end) else $error("no line end");
    property p_lb; in_line_valid |=> out_line_b == $past(in_line_b); endproperty
    a_lb: assert property (p_lb) else $error("line select wrong");
endmodule : lpwc_crop_chk

bind lpwc_crop lpwc_crop_chk #(.LINE_PIX(LINE_PIX)) chk_u (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .in_line_valid, .in_pix_valid, .in_line_b, .out_line_valid,
    .out_pix_valid, .out_line_b, .out_pix, .out_line_end);

// file: testbench.sv
module testbench
    import lpwc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LP = 2048;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, out_line_valid, out_pix_valid, out_line_b, out_line_end;
    logic win_range_err, er;
    logic in_line_valid = 1'b0, in_pix_valid = 1'b0, in_line_b = 1'b0;
    logic [LPWC_DATA_W-1:0] in_pix = 16'h0000, out_pix, g_first, g_last;
    int g_n, n_fail = 0, num_checks = 0;
    lpwc_crop #(.LINE_PIX(LP)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .in_line_valid, .in_pix_valid, .in_line_b,
        .in_pix, .out_line_valid, .out_pix_valid, .out_line_b, .out_pix, .out_line_end,
        .win_range_err);
    lpwc_grabber grab_u (.pclk, .line_valid(out_line_valid), .pix_valid(out_pix_valid),
        .pix(out_pix), .n_pix(g_n), .first_pix(g_first), .last_pix(g_last));
    initial begin
        forever #2 pclk = ~pclk;
    end
    task test_done;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            n_fail++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task send_line(input logic b);
        int i;
        @(posedge pclk);
        in_line_valid <= 1'b1;
        in_line_b <= b;
        for (i = 1; i <= LP; i++) begin
            @(posedge pclk);
            in_pix_valid <= 1'b1;
            in_pix <= i[15:0];
        end
        @(posedge pclk);
        in_pix_valid <= 1'b0;
        in_line_valid <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : send_line
    task line_chk(input int n, input int f, input int l);
        chk(g_n, n);
        chk({16'h0000, g_first}, f);
        chk({16'h0000, g_last}, l);
    endtask : line_chk
    task s_crop;
        apb(1'b1, LPWC_OFS_FIRST, 32'h21);
        apb(1'b1, LPWC_OFS_COUNT, 32'h100);
        apb(1'b0, LPWC_OFS_FIRST, 32'h0);
        chk(rd, 32'h21);
        send_line(1'b0);
        line_chk(256, 33, 33 + 256 - 1);
        send_line(1'b1);
        line_chk(256, 33, 33 + 256 - 1);
        apb(1'b1, LPWC_OFS_CTRL, 32'h2);
        send_line(1'b0);
        line_chk(256, 33, 33 + 256 - 1);
        send_line(1'b1);
        line_chk(LP, 1, LP);
        apb(1'b1, LPWC_OFS_CTRL, 32'h0);
    endtask : s_crop
    task s_switch;
        fork
            send_line(1'b0);
            begin
                repeat (200) @(posedge pclk);
                apb(1'b1, LPWC_OFS_FIRST, 32'h41);
                apb(1'b0, LPWC_OFS_STATUS, 32'h0);
                chk(rd, 32'h3);
            end
        join
        line_chk(256, 33, 33 + 256 - 1);
        send_line(1'b0);
        line_chk(256, 65, 65 + 256 - 1);
    endtask : s_switch
    task s_bin;
        apb(1'b1, LPWC_OFS_CTRL, 32'h1);
        apb(1'b1, LPWC_OFS_FIRST, 32'h11);
        apb(1'b1, LPWC_OFS_COUNT, 32'h80);
        send_line(1'b0);
        line_chk(128, 2 * 17 - 1, 2 * (17 + 128 - 1) - 1);
        apb(1'b0, LPWC_OFS_STATUS, 32'h0);
        chk(rd, 32'h4);
        apb(1'b1, LPWC_OFS_FIRST, 32'h381);
        repeat (4) @(posedge pclk);
        chk({31'h0, win_range_err}, 32'h0);
        apb(1'b1, LPWC_OFS_FIRST, 32'h391);
        repeat (4) @(posedge pclk);
        chk({31'h0, win_range_err}, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
    endtask : s_bin
    task s_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, LPWC_OFS_FIRST, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, LPWC_OFS_COUNT, 32'h0);
        chk(rd, 32'h1000);
        send_line(1'b0);
        line_chk(LP, 1, LP);
    endtask : s_reset
    initial begin
        repeat (100000) @(posedge pclk);
        n_fail++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        s_crop();
        s_switch();
        s_bin();
        s_reset();
        test_done();
    end
endmodule : testbench
